/* lss_led_sink.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lss_defs.svh"
module lss_led_sink #(
  parameter int CHANNELS = `LSS_CHANNELS
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic serial_shift_clock_i,
  input wire logic serial_data_in_i,
  input wire logic load_strobe_i,
  input wire logic output_disable_i,
  input wire lss_pkg::lss_word_t open_led_flag_i,
  input wire logic thermal_warning_flag_i,
  output logic serial_data_out_o,
  output lss_pkg::lss_word_t current_sink_channel_o
);
  import lss_pkg::*;

  logic sclk_rise;
  logic lat_rise;
  logic dis_rise;
  logic dis_level;
  logic sin_level;
  wire lss_word_t open_level;
  logic therm_level;
  lss_word_t shift_q;
  lss_word_t latch_q;
  lss_word_t status_capture_latch_q;
  lss_word_t outs_q;
  logic serial_data_out_q;

  lss_pin_sync u_sclk (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_shift_clock_i),
    .level_o(),
    .rise_o(sclk_rise),
    .fall_o()
  );

  lss_pin_sync u_lat (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(load_strobe_i),
    .level_o(),
    .rise_o(lat_rise),
    .fall_o()
  );

  // level follows the pin through reset, so a held-high disable keeps outputs off
  lss_pin_sync u_dis (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(output_disable_i),
    .level_o(dis_level),
    .rise_o(dis_rise),
    .fall_o()
  );

  // data level settles before the clock edge is seen; controller must hold it past
  lss_pin_sync u_sin (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_data_in_i),
    .level_o(sin_level),
    .rise_o(),
    .fall_o()
  );

  // analog flags: each bit through its own three-stage catch
  for (genvar g = 0; g < CHANNELS; g++) begin : g_open_sync
    lss_pin_sync u_open (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(open_led_flag_i[g]),
      .level_o(open_level[g]),
      .rise_o(),
      .fall_o()
    );
  end

  lss_pin_sync u_therm (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(thermal_warning_flag_i),
    .level_o(therm_level),
    .rise_o(),
    .fall_o()
  );

  // status held from one disable rise until the next disable rise; no reset, like the part
  always_ff @(posedge clk_sys_i) begin
    if (dis_rise) begin // RULE13
      status_capture_latch_q <= therm_level ? '1 : open_level; // RULE14
    end
  end

  // shift register and latch deliberately unreset: power-up is random
  always_ff @(posedge clk_sys_i) begin
    if (lat_rise) begin
      shift_q <= status_capture_latch_q; // RULE5
    end else if (sclk_rise) begin
      shift_q <= {shift_q[CHANNELS-2:0], sin_level}; // RULE2 RULE12
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (lat_rise) begin
      latch_q <= shift_q; // RULE1 RULE4 RULE9
    end
  end

  // serial_data_out follows the MSB only at the shift or latch edge
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      serial_data_out_q <= 1'b0;
    end else if (lat_rise) begin
      serial_data_out_q <= status_capture_latch_q[CHANNELS-1]; // RULE5
    end else if (sclk_rise) begin
      serial_data_out_q <= shift_q[CHANNELS-2]; // RULE3 RULE12
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || dis_level) begin
      outs_q <= '0; // RULE8
    end else begin
      outs_q <= latch_q; // RULE7 RULE16
    end
  end

  assign serial_data_out_o = serial_data_out_q;
  assign current_sink_channel_o = outs_q;

  property p_disable_off;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      dis_level |=> (current_sink_channel_o == '0);
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("output on while disabled"); // RULE8

  property p_follow_latch;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !dis_level |=> (current_sink_channel_o === $past(latch_q));
  endproperty
  a_follow_latch: assert property (p_follow_latch) else $error("output not latch"); // RULE7

  property p_load;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      lat_rise |=> (latch_q === $past(shift_q));
  endproperty
  a_load: assert property (p_load) else $error("latch not loaded"); // RULE4

  property p_status_load;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      lat_rise |=> (shift_q === $past(status_capture_latch_q));
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded"); // RULE5

  sequence s_shift_edge;
    sclk_rise && !lat_rise;
  endsequence

  property p_shift;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_shift_edge |=> (shift_q === {$past(shift_q[CHANNELS-2:0]), $past(sin_level)});
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong"); // RULE2

  property p_serial_data_out_msb;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_shift_edge |=> (serial_data_out_o === shift_q[CHANNELS-1]);
  endproperty
  a_serial_data_out_msb: assert property (p_serial_data_out_msb) else $error("serial_data_out not msb"); // RULE12

  property p_serial_data_out_stable;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !sclk_rise && !lat_rise |=> (serial_data_out_o === $past(serial_data_out_o));
  endproperty
  a_serial_data_out_stable: assert property (p_serial_data_out_stable) else $error("serial_data_out moved off edge"); // RULE3

  property p_thermal;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      dis_rise && therm_level |=> (status_capture_latch_q == 16'hffff);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal not all ones"); // RULE14

  property p_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !dis_rise |=> (status_capture_latch_q === $past(status_capture_latch_q));
  endproperty
  a_hold: assert property (p_hold) else $error("status changed"); // RULE13

  property p_open_capture;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      dis_rise && !therm_level |=> (status_capture_latch_q === $past(open_level));
  endproperty
  a_open_capture: assert property (p_open_capture) else $error("open flags not captured"); // RULE13

  property p_serial_data_out_load;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      lat_rise |=> (serial_data_out_o === shift_q[CHANNELS-1]);
  endproperty
  a_serial_data_out_load: assert property (p_serial_data_out_load) else $error("serial_data_out not status msb"); // RULE5

  property p_latch_steady;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !lat_rise |=> (latch_q === $past(latch_q));
  endproperty
  a_latch_steady: assert property (p_latch_steady) else $error("latch moved off load"); // RULE4

  property p_shift_steady;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !sclk_rise && !lat_rise |=> (shift_q === $past(shift_q));
  endproperty
  a_shift_steady: assert property (p_shift_steady) else $error("shift moved off edge"); // RULE2

  // no load and no disable change: outputs must hold one cycle later
  sequence s_outs_quiet;
    !lat_rise ##1 (dis_level == $past(dis_level));
  endsequence

  property p_outs_steady;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_outs_quiet |=> (current_sink_channel_o === $past(current_sink_channel_o));
  endproperty
  a_outs_steady: assert property (p_outs_steady) else $error("outputs moved"); // RULE7
endmodule
`default_nettype wire

/* lss_defs.svh */
// Summary of operation
// (RULE1) The device holds a 16-bit shift register and a 16-bit on/off latch, one bit per channel.
// (RULE2) Each serial clock rising edge captures serial_data_in into the shift register LSB.
// (RULE3) serial_data_out changes on the serial clock rising edge only; the code also updates it on the load_strobe rising edge.
// (RULE4) A load_strobe rising edge copies the whole shift register into the on/off latch.
// (RULE5) The same load_strobe edge overwrites the shift register with the captured status bits.
// (RULE6) The controller pulses load_strobe once per new data, or status lands in the latch.
// (RULE7) With output_disable low, a channel sinks when its latch bit is 1 and is off when 0.
// (RULE8) With output_disable high, every channel is forced off.
// (RULE9) Shift register and latch have no defined start value; valid data must be latched first.
// (RULE10) The controller should hold output_disable high until valid data is latched.
// (RULE11) The controller should latch 0 for unconnected channels before enabling outputs.
// (RULE12) Each serial clock rising edge moves all bits toward the MSB; the MSB drives serial_data_out.
// (RULE13) Status is captured on the output_disable rising edge and held until it goes low; the code holds it until the next output_disable rising edge.
// (RULE14) An active thermal warning makes all 16 status bits read as 1.
// (RULE15) The controller waits 100 ns after a load_strobe rising edge before the next serial clock rise.
// (RULE16) Latch bit n drives channel n, bit 0 the first channel, bit 15 the last.
// (RULE17) A chain is fed 16 bits per device, farthest first, then one load_strobe pulse.
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH
`define LSS_CHANNELS 16
`define LSS_SYNC_STAGES 3
`define LSS_CLK_PERIOD_NS 10
`define LSS_LAT_TO_SCLK_NS 100
`define LSS_LAT_TO_SCLK_CYC ((`LSS_LAT_TO_SCLK_NS + `LSS_CLK_PERIOD_NS - 1) / `LSS_CLK_PERIOD_NS)
`endif

/* lss_pkg.sv */
package lss_pkg;
  typedef logic [15:0] lss_word_t;
  typedef enum logic [1:0] {
    LSS_EDGE_NONE = 2'b00,
    LSS_EDGE_RISE = 2'b01,
    LSS_EDGE_FALL = 2'b10
  } lss_edge_t;
endpackage

/* lss_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// three-stage pin synchroniser; level changes once stages two and three agree
module lss_pin_sync (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk_sys_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk_sys_i) begin
    // reset takes the settled pin level, so release shows no false edge
    if (sys_rst_i) begin
      level_q <= s2_q;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  always_comb begin
    level_o = level_q;
    rise_o = (s2_q == s3_q) && s3_q && !level_q;
    fall_o = (s2_q == s3_q) && !s3_q && level_q;
  end
endmodule
`default_nettype wire

/* lss_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// display controller stand-in; pins move only on system clock edges
module lss_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic serial_data_out_i,
  output logic serial_shift_clock_o,
  output logic serial_data_in_o,
  output logic load_strobe_o,
  output logic output_disable_o
);
  import lss_pkg::*;
  initial begin
    serial_shift_clock_o = 1'b0;
    serial_data_in_o = 1'b0;
    load_strobe_o = 1'b0;
    output_disable_o = 1'b1;
  end
  // msb first, so the first bit ends farthest along; data held 40 ns each side
  task automatic send_word(input lss_word_t w, output lss_word_t rd);
    for (int i = 15; i >= 0; i--) begin
      serial_data_in_o <= w[i];
      repeat (4) @(posedge clk_sys_i);
      rd[i] = serial_data_out_i;
      serial_shift_clock_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      serial_shift_clock_o <= 1'b0;
    end
    serial_data_in_o <= ~serial_data_in_o;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic latch();
    load_strobe_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    load_strobe_o <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
  endtask
  task automatic set_blank(input logic v);
    output_disable_o <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

/* led_sink_onoff_shift_latch_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module led_sink_onoff_shift_latch_bench;
  import lss_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic thermal = 1'b0;
  logic sclk, serial_data_in, lat, blank, serial_data_out;
  lss_word_t open_led = 16'h0000;
  lss_word_t outs, w, rd, st;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  lss_led_sink #(.CHANNELS(16)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .serial_shift_clock_i(sclk), .serial_data_in_i(serial_data_in), .load_strobe_i(lat),
    .output_disable_i(blank), .open_led_flag_i(open_led), .thermal_warning_flag_i(thermal),
    .serial_data_out_o(serial_data_out), .current_sink_channel_o(outs));
  lss_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .serial_data_out_i(serial_data_out),
    .serial_shift_clock_o(sclk), .serial_data_in_o(serial_data_in), .load_strobe_o(lat),
    .output_disable_o(blank));
  function automatic lss_word_t exp_status(input lss_word_t ol, input logic th);
    return th ? 16'hffff : ol;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // six tests take about 2800 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h6eef));
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    // clear the random latch before any channel may light
    u_ctrl.send_word(16'h0000, rd);
    u_ctrl.latch();
    u_ctrl.set_blank(1'b0);
    for (int t = 0; t < 6; t++) begin
      w = (t == 0) ? 16'h0000 : (t == 1) ? 16'hffff : 16'($urandom);
      open_led <= 16'($urandom);
      thermal <= t[0];
      u_ctrl.set_blank(1'b0);
      u_ctrl.set_blank(1'b1);
      st = exp_status(open_led, thermal);
      // flags move after capture; the status latch must not follow
      open_led <= ~open_led;
      thermal <= ~thermal;
      u_ctrl.send_word(w, rd);
      u_ctrl.latch();
      if (t[1]) u_ctrl.latch();
      `CHK(outs, 16'h0000)
      u_ctrl.set_blank(1'b0);
      `CHK(outs, t[1] ? st : w)
      w = 16'($urandom);
      u_ctrl.send_word(w, rd);
      `CHK(rd, st)
      u_ctrl.send_word(~w, rd);
      `CHK(rd, w)
      $display("test %0d done", t);
    end
    summarize();
  end
endmodule
`default_nettype wire
